/* rtl/vpw_link_consts.vh */
`ifndef VPW_LINK_CONSTS_VH
`define VPW_LINK_CONSTS_VH

// register offsets
`define OFS_DELAY_COMP      3'h0
`define OFS_FIRST_CTRL      3'h1
`define OFS_SECOND_CTRL     3'h2
`define OFS_STATE_VECTOR    3'h3
`define OFS_LINK_DATA       3'h4
`define OFS_LINK_STATUS     3'h5

// field positions
`define BIT_XCVR_SELECT     6
`define BIT_IRQ_ENABLE      1
`define BIT_RX_QUAD_ENABLE  4
`define BIT_ST_TX_EMPTY     0
`define BIT_ST_RX_FRAME     1
`define BIT_ST_TX_BUSY      2

// reset values
`define RST_DELAY_COMP      8'h07
`define RST_FIRST_CTRL      8'h00
`define RST_SECOND_CTRL     8'h00

// state vector codes
`define SV_NONE             8'h00
`define SV_RX_FULL          8'h0C
`define SV_TX_EMPTY         8'h10
`define SV_ARB_LOST         8'h14
`define SV_CRC_ERR          8'h18
`define SV_SYMBOL_ERR       8'h1C

// crc
`define CRC_INIT            8'hFF
`define CRC_POLY            8'h1D
`define CRC_RESIDUE         8'hC4

// delay compensation: 0000 selects the base, each step adds one microsecond
`define DELAY_BASE_US       9

// timing, in microseconds except the clock period in picoseconds and the tick in clock cycles
`define CLK_PERIOD_PS       25000
`define TICK_US             1
`define TICK_CYCLES         ((`TICK_US * 1000000) / `CLK_PERIOD_PS)
`define ACT_MIN_US          34
`define SHORT_MAX_US        96
`define LONG_MAX_US         163
`define SOF_MAX_US          239
`define IFS_US              300
`define Q_ACT_MIN_US        8
`define Q_SHORT_MAX_US      24
`define Q_LONG_MAX_US       40
`define Q_SOF_MAX_US        59
`define TX_SHORT_US         64
`define TX_LONG_US          128
`define TX_SOF_US           200
`define TX_EOD_US           200
`define DRIVE_SLACK_US      4

`endif

/* rtl/vpw_bus_protocol_error_handler.v */
// Summary of operation
// - never transmit quad rate; receive it if enabled
// - quad traffic ignored silently while enable clear
// - receive frames with unlimited data bytes
// - transmit while software keeps supplying bytes
// - own invalid bits or framing abort, code 1C
// - transmission error raises interrupt when enabled
// - residue not C4 after frame flags code 18
// - after crc error wait for next SOF
// - invalid symbol 1C; transmitting reports 14 first
// - off-boundary EOD or EOF is framing error
// - active seen during own EOD is framing error
// - never transmit while bus held active
// - undriveable bus: 1C, abort, await new command
// - recover from temporary faults without reset
// - BREAK raises 1C; vector read clears it
// - after BREAK wait idle, then SOF
// - controller never sends a BREAK
// - noise during transmit aborts, raises 1C
// - delay resets to 16us, range 9..24
// - delay register writable once, always readable
// - transceiver select 1 on-chip, 0 external
// - offset field maps linearly 9..24 us
// - interrupts reach cpu only with enable set
`timescale 1ns/100ps
`include "vpw_link_consts.vh"
`default_nettype none

module vpw_bus_protocol_error_handler (
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire [2:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  input  wire       busRxIn,
  output reg        busTxOut,
  output wire       irqOut
);

  localparam RX_WAIT_IDLE = 2'd0;
  localparam RX_WAIT_SOF  = 2'd1;
  localparam RX_FRAME     = 2'd2;

  localparam TX_IDLE      = 2'd0;
  localparam TX_SOF       = 2'd1;
  localparam TX_BITS      = 2'd2;
  localparam TX_EOD       = 2'd3;

  localparam integer TICK_LAST_INT = `TICK_CYCLES - 1;
  localparam [5:0]   TICK_LAST     = TICK_LAST_INT[5:0];

  reg  [5:0] tickCnt_r;
  reg        usTick_r;
  reg        rxS1_r;
  reg        rxS2_r;
  reg        rxS3_r;
  reg        rxLevel_r;
  reg  [8:0] levelCnt_r;
  reg  [1:0] rxState_r;
  reg        frameQuad_r;
  reg  [2:0] rxBitCnt_r;
  reg  [7:0] rxShift_r;
  reg  [7:0] rxCrc_r;
  reg  [7:0] rxByte_r;
  reg  [1:0] txState_r;
  reg  [8:0] txCnt_r;
  reg  [7:0] txShift_r;
  reg  [2:0] txBitCnt_r;
  reg  [7:0] holdByte_r;
  reg        holdFull_r;
  reg  [7:0] delayComp_r;
  reg        delayWritten_r;
  reg  [7:0] firstCtrl_r;
  reg  [7:0] secondCtrl_r;
  reg        arbLost_r;
  reg        symErr_r;
  reg        crcErr_r;
  reg        rxFull_r;

  // combinational decode
  reg        edgeEv;
  reg        activeEnd;
  reg        passiveEnd;
  reg  [10:0] widthEff;
  reg        symInvalid;
  reg        symShort;
  reg        symLong;
  reg        sof1x;
  reg        sofQuad;
  reg        eodHit;
  reg        breakHit;
  reg        bitEv;
  reg        bitVal;
  reg  [7:0] crcNext;
  reg        rxSymErr;
  reg        rxFrameErr;
  reg        rxCrcBad;
  reg        rxByteDone;
  reg        txBusy;
  reg        txDriveFail;
  reg        txArbLoss;
  reg        txEodFail;
  reg        txAbort;
  reg  [8:0] txDur;
  reg  [7:0] svCode;
  reg        svRead;
  reg  [8:0] delayUs;

  wire rxQuadEnable = secondCtrl_r[`BIT_RX_QUAD_ENABLE];
  wire irqEnable    = firstCtrl_r[`BIT_IRQ_ENABLE];
  wire busIdle      = !rxLevel_r && (levelCnt_r >= 9'd`IFS_US);
  wire txEmptyShown = txBusy && !holdFull_r;

  // one-microsecond enable; all symbol timing counts these pulses
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt_r <= 6'h00;
      usTick_r  <= 1'b0;
    end else if (tickCnt_r == TICK_LAST) begin
      tickCnt_r <= 6'h00;
      usTick_r  <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 6'd1;
      usTick_r  <= 1'b0;
    end
  end

  always @* begin
    edgeEv     = (rxS2_r == rxS3_r) && (rxS3_r != rxLevel_r);
    activeEnd  = edgeEv && rxLevel_r;
    passiveEnd = edgeEv && !rxLevel_r;
    // inside a quad frame widths are scaled up to the normal-rate scale
    widthEff   = frameQuad_r ? {levelCnt_r, 2'b00} : {2'b00, levelCnt_r};
    symInvalid = widthEff < 11'd`ACT_MIN_US;
    symShort   = !symInvalid && (widthEff < 11'd`SHORT_MAX_US);
    symLong    = (widthEff >= 11'd`SHORT_MAX_US) && (widthEff < 11'd`LONG_MAX_US);
    sof1x      = (levelCnt_r >= 9'd`LONG_MAX_US) && (levelCnt_r < 9'd`SOF_MAX_US);
    sofQuad    = (levelCnt_r >= 9'd`Q_LONG_MAX_US) && (levelCnt_r < 9'd`Q_SOF_MAX_US);
    eodHit     = usTick_r && !rxLevel_r && (rxState_r == RX_FRAME) &&
                 (levelCnt_r == (frameQuad_r ? 9'd`Q_LONG_MAX_US : 9'd`LONG_MAX_US) - 9'd1);
    breakHit   = usTick_r && rxLevel_r && (rxState_r != RX_WAIT_IDLE) &&
                 (levelCnt_r == 9'd`SOF_MAX_US - 9'd1);
    bitEv      = (rxState_r == RX_FRAME) && (activeEnd || passiveEnd) && (symShort || symLong);
    bitVal     = symLong ^ activeEnd;
    crcNext    = {rxCrc_r[6:0], 1'b0} ^ ((rxCrc_r[7] ^ bitVal) ? `CRC_POLY : 8'h00);
    rxSymErr   = (rxState_r == RX_FRAME) && edgeEv && !(symShort || symLong);
    rxFrameErr = eodHit && (rxBitCnt_r != 3'd0);
    rxCrcBad   = eodHit && (rxBitCnt_r == 3'd0) && (rxCrc_r != `CRC_RESIDUE);
    rxByteDone = bitEv && (rxBitCnt_r == 3'd7);
    txBusy     = (txState_r != TX_IDLE);
    delayUs    = 9'd`DELAY_BASE_US + {5'd0, delayComp_r[3:0]};
    txDur      = (txShift_r[7] ^ busTxOut) ? 9'd`TX_LONG_US : 9'd`TX_SHORT_US;
    txDriveFail = usTick_r && busTxOut && !rxLevel_r &&
                  (txCnt_r == delayUs + 9'd`DRIVE_SLACK_US);
    txArbLoss  = (txState_r == TX_BITS) && !busTxOut && rxLevel_r &&
                 (txCnt_r > delayUs + 9'd`DRIVE_SLACK_US);
    txEodFail  = (txState_r == TX_EOD) && rxLevel_r &&
                 (txCnt_r > delayUs + 9'd`DRIVE_SLACK_US);
    txAbort    = txBusy && (txDriveFail || txArbLoss || txEodFail || rxSymErr ||
                 rxFrameErr || breakHit);
    // loss of arbitration outranks the symbol code it queues in front of
    if (arbLost_r)
      svCode = `SV_ARB_LOST;
    else if (symErr_r)
      svCode = `SV_SYMBOL_ERR;
    else if (crcErr_r)
      svCode = `SV_CRC_ERR;
    else if (rxFull_r)
      svCode = `SV_RX_FULL;
    else if (txEmptyShown)
      svCode = `SV_TX_EMPTY;
    else
      svCode = `SV_NONE;
    svRead = regRd && (regAddr == `OFS_STATE_VECTOR);
  end

  // receive pin: three stages, a change counts once stages two and three agree
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxS1_r     <= 1'b0;
      rxS2_r     <= 1'b0;
      rxS3_r     <= 1'b0;
      rxLevel_r  <= 1'b0;
      levelCnt_r <= 9'h000;
    end else begin
      rxS1_r <= busRxIn;
      rxS2_r <= rxS1_r;
      rxS3_r <= rxS2_r;
      if (edgeEv) begin
        rxLevel_r  <= rxS3_r;
        levelCnt_r <= 9'h000;
      end else if (usTick_r && (levelCnt_r != 9'h1FF)) begin
        levelCnt_r <= levelCnt_r + 9'd1;
      end
    end
  end

  // receiver
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxState_r   <= RX_WAIT_IDLE;
      frameQuad_r <= 1'b0;
      rxBitCnt_r  <= 3'd0;
      rxShift_r   <= 8'h00;
      rxCrc_r     <= `CRC_INIT;
      rxByte_r    <= 8'h00;
    end else begin
      case (rxState_r)
        RX_WAIT_IDLE: begin
          if (busIdle)
            rxState_r <= RX_WAIT_SOF;
        end
        RX_WAIT_SOF: begin
          // quad-rate start is noise unless enabled: no flag, no byte
          if (activeEnd && (sof1x || (sofQuad && rxQuadEnable))) begin
            rxState_r   <= RX_FRAME;
            frameQuad_r <= !sof1x;
            rxBitCnt_r  <= 3'd0;
            rxCrc_r     <= `CRC_INIT;
          end
        end
        RX_FRAME: begin
          if (breakHit)
            rxState_r <= RX_WAIT_IDLE;
          else if (rxSymErr || eodHit)
            rxState_r <= RX_WAIT_SOF;
          else if (bitEv) begin
            // no byte limit: the frame runs until an EOD, a symbol error or a BREAK
            rxShift_r  <= {rxShift_r[6:0], bitVal};
            rxCrc_r    <= crcNext;
            rxBitCnt_r <= rxBitCnt_r + 3'd1;
            if (rxBitCnt_r == 3'd7)
              rxByte_r <= {rxShift_r[6:0], bitVal};
          end
        end
        default: rxState_r <= RX_WAIT_IDLE;
      endcase
      if (breakHit)
        rxState_r <= RX_WAIT_IDLE;
    end
  end

  // transmitter: longest active it ever drives is the SOF, so no BREAK is possible
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txState_r  <= TX_IDLE;
      txCnt_r    <= 9'h000;
      txShift_r  <= 8'h00;
      txBitCnt_r <= 3'd0;
      busTxOut   <= 1'b0;
      holdByte_r <= 8'h00;
      holdFull_r <= 1'b0;
    end else begin
      if (regWr && (regAddr == `OFS_LINK_DATA)) begin
        holdByte_r <= regWrData;
        holdFull_r <= 1'b1;
      end
      if (usTick_r && (txCnt_r != 9'h1FF))
        txCnt_r <= txCnt_r + 9'd1;
      if (txAbort) begin
        // pending byte dropped: only a fresh data write restarts the link
        txState_r  <= TX_IDLE;
        busTxOut   <= 1'b0;
        holdFull_r <= regWr && (regAddr == `OFS_LINK_DATA);
      end else begin
        case (txState_r)
          TX_IDLE: begin
            // a bus held active never reads idle, so a short to battery stalls here
            if (holdFull_r && busIdle && (rxState_r != RX_FRAME)) begin
              txState_r  <= TX_SOF;
              txShift_r  <= holdByte_r;
              holdFull_r <= 1'b0;
              busTxOut   <= 1'b1;
              txCnt_r    <= 9'h000;
            end
          end
          TX_SOF: begin
            if (usTick_r && (txCnt_r == 9'd`TX_SOF_US - 9'd1)) begin
              txState_r  <= TX_BITS;
              busTxOut   <= 1'b0;
              txBitCnt_r <= 3'd0;
              txCnt_r    <= 9'h000;
            end
          end
          TX_BITS: begin
            if (usTick_r && (txCnt_r == txDur - 9'd1)) begin
              busTxOut   <= !busTxOut;
              txCnt_r    <= 9'h000;
              txBitCnt_r <= txBitCnt_r + 3'd1;
              txShift_r  <= {txShift_r[6:0], 1'b0};
              if (txBitCnt_r == 3'd7) begin
                if (holdFull_r) begin
                  txShift_r  <= holdByte_r;
                  holdFull_r <= 1'b0;
                end else begin
                  txState_r <= TX_EOD;
                  busTxOut  <= 1'b0;
                end
              end
            end
          end
          TX_EOD: begin
            if (usTick_r && (txCnt_r == 9'd`TX_EOD_US - 9'd1))
              txState_r <= TX_IDLE;
          end
          default: txState_r <= TX_IDLE;
        endcase
      end
    end
  end

  // registers and sticky conditions; a new event wins over a clearing read
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      delayComp_r    <= `RST_DELAY_COMP;
      delayWritten_r <= 1'b0;
      firstCtrl_r    <= `RST_FIRST_CTRL;
      secondCtrl_r   <= `RST_SECOND_CTRL;
      arbLost_r      <= 1'b0;
      symErr_r       <= 1'b0;
      crcErr_r       <= 1'b0;
      rxFull_r       <= 1'b0;
      regRdData      <= 8'h00;
    end else begin
      if (regWr && (regAddr == `OFS_DELAY_COMP) && !delayWritten_r) begin
        delayComp_r    <= regWrData & 8'h4F;
        delayWritten_r <= 1'b1;
      end
      if (regWr && (regAddr == `OFS_FIRST_CTRL))
        firstCtrl_r <= regWrData;
      if (regWr && (regAddr == `OFS_SECOND_CTRL))
        secondCtrl_r <= regWrData;
      arbLost_r <= (txBusy && (txArbLoss || rxSymErr)) ||
                   (arbLost_r && !(svRead && (svCode == `SV_ARB_LOST)));
      symErr_r  <= rxSymErr || rxFrameErr || breakHit || txDriveFail || txEodFail ||
                   (symErr_r && !(svRead && (svCode == `SV_SYMBOL_ERR)));
      crcErr_r  <= rxCrcBad || (crcErr_r && !(svRead && (svCode == `SV_CRC_ERR)));
      rxFull_r  <= rxByteDone || (rxFull_r && !(regRd && (regAddr == `OFS_LINK_DATA)));
      if (regRd) begin
        case (regAddr)
          `OFS_DELAY_COMP:   regRdData <= delayComp_r;
          `OFS_FIRST_CTRL:   regRdData <= firstCtrl_r;
          `OFS_SECOND_CTRL:  regRdData <= secondCtrl_r;
          `OFS_STATE_VECTOR: regRdData <= svCode;
          `OFS_LINK_DATA:    regRdData <= rxByte_r;
          `OFS_LINK_STATUS:  regRdData <= {5'd0, txBusy, (rxState_r == RX_FRAME), !holdFull_r};
          default:           regRdData <= 8'h00;
        endcase
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  // request stays up until every source is cleared; enable only gates it
  assign irqOut = irqEnable && (svCode != `SV_NONE);

endmodule

`default_nettype wire

/* verification/vpw_link_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "vpw_link_consts.vh"
module vpw_link_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       busRxIn,
  input wire logic       busTxOut,
  input wire logic       irqOut
);
  localparam int IdleMin = 11900;
  // counters saturate so a long idle stretch never wraps into a false start
  logic        lock_r;
  logic [7:0]  delay_r;
  logic        irqEn_r;
  logic [13:0] rxIdle_r;
  logic [13:0] txLow_r;
  logic [13:0] txHigh_r;
  logic [13:0] noEcho_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_r   <= 1'b0;
      delay_r  <= `RST_DELAY_COMP;
      irqEn_r  <= 1'b0;
      rxIdle_r <= 14'h0000;
      txLow_r  <= 14'h3FFF;
      txHigh_r <= 14'h0000;
      noEcho_r <= 14'h0000;
    end else begin
      if (regWr && regAddr == `OFS_DELAY_COMP && !lock_r) begin
        lock_r  <= 1'b1;
        delay_r <= regWrData & 8'h4F;
      end
      if (regWr && regAddr == `OFS_FIRST_CTRL)
        irqEn_r <= regWrData[`BIT_IRQ_ENABLE];
      rxIdle_r <= busRxIn ? 14'h0000 : rxIdle_r + {13'h0000, ~&rxIdle_r};
      txLow_r  <= busTxOut ? 14'h0000 : txLow_r + {13'h0000, ~&txLow_r};
      txHigh_r <= busTxOut ? txHigh_r + {13'h0000, ~&txHigh_r} : 14'h0000;
      noEcho_r <= (busTxOut && !busRxIn) ? noEcho_r + {13'h0000, ~&noEcho_r} : 14'h0000;
    end
  end
  chk_delay_value: assert property (@(posedge core_clk) disable iff (sys_rst)
    regRd && regAddr == `OFS_DELAY_COMP |=> regRdData == delay_r) else $error("delay readback wrong");
  chk_vector_codes: assert property (@(posedge core_clk) disable iff (sys_rst)
    regRd && regAddr == `OFS_STATE_VECTOR |=> regRdData inside {8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C})
    else $error("state vector code out of set");
  chk_read_idle_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    !regRd |=> regRdData == 8'h00) else $error("read data outside read cycle");
  chk_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    irqOut |-> irqEn_r) else $error("interrupt without enable");
  chk_irq_on_abort: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(busTxOut) && noEcho_r > 14'd600 && irqEn_r |-> ##[0:4] irqOut) else $error("abort without interrupt");
  chk_tx_after_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(busTxOut) && txLow_r > 14'd6000 |-> rxIdle_r >= IdleMin) else $error("frame started on busy bus");
  chk_no_break_sent: assert property (@(posedge core_clk) disable iff (sys_rst)
    txHigh_r <= 14'd8010) else $error("active drive longer than a start symbol");
  chk_abort_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
    noEcho_r <= 14'd40 * (14'd14 + {10'h000, delay_r[3:0]})) else $error("undriven bus not aborted in time");
  chk_full_rate_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(busTxOut) && noEcho_r <= 14'd600 |-> txHigh_r >= 14'd2500) else $error("active pulse too short");
endmodule
bind vpw_bus_protocol_error_handler vpw_link_monitor vpw_link_monitor_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .busRxIn(busRxIn),
  .busTxOut(busTxOut), .irqOut(irqOut));
`default_nettype wire

/* verification/vpw_transceiver_model.sv */
`timescale 1ns/100ps
`default_nettype none
// external transceiver: software keeps the select bit at 0 for it
module vpw_transceiver_model #(
  parameter int EchoCycles = 480
) (
  input  wire logic       core_clk,
  input  wire logic       txDrive,
  input  wire logic       inject,
  input  wire logic [1:0] faultMode,
  output wire logic       busRx
);
  // echo lags by a fixed 12 us, inside the default compensation window
  logic [EchoCycles-1:0] echo_r;
  initial echo_r = '0;
  always @(posedge core_clk) echo_r <= {echo_r[EchoCycles-2:0], txDrive};
  // other nodes win as active; mode 1 shorts to battery, mode 2 to ground
  assign busRx = (faultMode == 2'd1) | ((faultMode != 2'd2) & (echo_r[EchoCycles-1] | inject));
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "vpw_link_consts.vh"
module testbench;
  logic       core_clk;
  logic       sys_rst;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic       regWr;
  logic       regRd;
  wire  [7:0] regRdData;
  wire        busRxIn;
  wire        busTxOut;
  wire        irqOut;
  logic       inject;
  logic [1:0] faultMode;
  logic [7:0] rdVal;
  int         mismatches;
  int         checks;

  vpw_bus_protocol_error_handler vpw_bus_protocol_error_handler_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .busRxIn(busRxIn), .busTxOut(busTxOut), .irqOut(irqOut));
  vpw_transceiver_model vpw_transceiver_model_inst (.core_clk(core_clk), .txDrive(busTxOut),
    .inject(inject), .faultMode(faultMode), .busRx(busRxIn));

  always #12.5 core_clk = ~core_clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_us(input int n);
    repeat (n * 40) @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [2:0] a, input logic [7:0] e, input string what);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rdVal = regRdData;
    check(what, rdVal, e);
  endtask
  task automatic expect_irq(input logic e);
    #1 check("irq", {7'h00, irqOut}, {7'h00, e});
  endtask
  // a limit that runs out ends the run, so a hang never stalls the report
  task automatic wait_tx(input logic lvl, input int limitUs);
    int n;
    n = 0;
    while (busTxOut !== lvl && n < limitUs * 40) begin
      @(posedge core_clk);
      n++;
    end
    check("transmit level", {7'h00, busTxOut}, {7'h00, lvl});
    if (busTxOut !== lvl)
      final_report();
  endtask
  task automatic hold_quiet(input int us, input string what);
    logic seen;
    seen = 1'b0;
    repeat (us * 40) begin
      @(posedge core_clk);
      seen = seen | busTxOut;
    end
    check(what, {7'h00, seen}, 8'h00);
  endtask
  // quad-rate frame: 50 us start, eight 16 us bits alternating from passive, carries 55
  task automatic quad_frame();
    @(posedge core_clk);
    inject <= 1'b1;
    wait_us(50);
    for (int i = 0; i < 8; i++) begin
      inject <= i[0];
      wait_us(16);
    end
    inject <= 1'b0;
    wait_us(60);
  endtask

  task automatic t_registers();
    expect_reg(`OFS_DELAY_COMP, 8'h07, "delay reset");
    expect_reg(`OFS_FIRST_CTRL, 8'h00, "ctrl1 reset");
    expect_reg(`OFS_SECOND_CTRL, 8'h00, "ctrl2 reset");
    expect_reg(3'h7, 8'h00, "unmapped");
    wr(`OFS_DELAY_COMP, 8'h0A);
    expect_reg(`OFS_DELAY_COMP, 8'h0A, "delay first write");
    wr(`OFS_DELAY_COMP, 8'h03);
    expect_reg(`OFS_DELAY_COMP, 8'h0A, "delay second write");
    wr(`OFS_FIRST_CTRL, 8'h02);
    $display("test registers done");
  endtask
  task automatic t_quad_off();
    quad_frame();
    expect_irq(1'b0);
    expect_reg(`OFS_STATE_VECTOR, 8'h00, "vector after ignored quad");
    $display("test quad disabled done");
  endtask
  task automatic t_quad_on();
    wr(`OFS_SECOND_CTRL, 8'h10);
    quad_frame();
    expect_irq(1'b1);
    expect_reg(`OFS_STATE_VECTOR, 8'h18, "crc code");
    expect_reg(`OFS_LINK_DATA, 8'h55, "quad byte");
    expect_reg(`OFS_STATE_VECTOR, 8'h00, "vector drained");
    $display("test quad enabled done");
  endtask
  task automatic t_break();
    inject <= 1'b1;
    wait_us(250);
    inject <= 1'b0;
    wait_us(10);
    expect_irq(1'b1);
    expect_reg(`OFS_STATE_VECTOR, 8'h1C, "break code");
    expect_reg(`OFS_STATE_VECTOR, 8'h00, "break cleared");
    expect_irq(1'b0);
    $display("test break done");
  endtask
  task automatic t_bus_faults();
    faultMode <= 2'd1;
    wait_us(250);
    expect_reg(`OFS_STATE_VECTOR, 8'h1C, "held active code");
    expect_reg(`OFS_LINK_STATUS, 8'h01, "holding empty");
    wr(`OFS_LINK_DATA, 8'hA5);
    hold_quiet(100, "tx on held bus");
    faultMode <= 2'd2;
    wait_tx(1'b1, 320);
    wait_tx(1'b0, 30);
    expect_irq(1'b1);
    expect_reg(`OFS_STATE_VECTOR, 8'h1C, "undriven bus code");
    hold_quiet(50, "tx after abort");
    faultMode <= 2'd0;
    $display("test bus faults done");
  endtask
  // another node drives active in our first passive bit: too short a passive, so 14 then 1C
  task automatic t_arbitration();
    wr(`OFS_LINK_DATA, 8'h55);
    wait_tx(1'b1, 5);
    expect_reg(`OFS_STATE_VECTOR, 8'h10, "holding empty code");
    expect_reg(`OFS_LINK_STATUS, 8'h05, "transmitting status");
    wait_tx(1'b0, 210);
    wait_us(30);
    inject <= 1'b1;
    wait_us(10);
    inject <= 1'b0;
    expect_irq(1'b1);
    expect_reg(`OFS_STATE_VECTOR, 8'h14, "lost arbitration code");
    expect_reg(`OFS_STATE_VECTOR, 8'h1C, "queued symbol code");
    expect_reg(`OFS_STATE_VECTOR, 8'h00, "arbitration drained");
    hold_quiet(20, "tx after arbitration loss");
    $display("test arbitration done");
  endtask

  initial begin
    core_clk   = 1'b0;
    sys_rst    = 1'b1;
    regAddr    = 3'h0;
    regWrData  = 8'h00;
    regWr      = 1'b0;
    regRd      = 1'b0;
    inject     = 1'b0;
    faultMode  = 2'd0;
    mismatches = 0;
    checks     = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_us(305);
    t_registers();
    t_quad_off();
    t_quad_on();
    t_bus_faults();
    t_arbitration();
    t_break();
    final_report();
  end
endmodule
`default_nettype wire
